// >>> src/smst_seq.sv
`timescale 1ns/1ps
// Notes on behaviour
// - read: strobes stay off output_enable_wait cycles after chip select.
// - read_wait below output_enable_wait: strobes start with chip select.
// - read strobe delay never exceeds read_wait cycles.
// - read strobe width is read_wait minus output_enable_wait plus one, read_wait plus one if read_wait is lower.
// - control bit 5 set: one extra cycle before output enable.
// - control bit 5 set: read strobe one cycle shorter.
// - every strobe lasts at least one cycle.
// - write enable at write_enable_wait plus one, write_wait plus one if lower; lanes one cycle earlier.
// - write enable width is write_wait minus write_enable_wait plus one, one cycle if write_wait is lower.
// - write byte lanes last that plus two, at least three cycles.
// - write data valid at least one cycle before write enable.
// - address held one cycle after write enable rises.
// - write data held one cycle after write enable rises.
module smst_seq #(
  parameter int unsigned AW     = 24,
  parameter int unsigned DW     = 16,
  parameter int unsigned WAIT_W = 4
) (
  input  wire logic                             sys_clk_i,
  input  wire logic                             resetn_i,
  input  wire logic                             ce_i,
  input  wire logic                             req_i,
  input  wire logic                             req_we_i,
  input  wire logic [AW-1:0]                    req_addr_i,
  input  wire logic [DW-1:0]                    req_wdata_i,
  input  wire logic [DW/8-1:0]                  req_be_i,
  input  wire logic [WAIT_W-1:0]                output_enable_wait_i,
  input  wire logic [WAIT_W-1:0]                read_wait_i,
  input  wire logic [WAIT_W-1:0]                write_enable_wait_i,
  input  wire logic [WAIT_W-1:0]                write_wait_i,
  input  wire logic [smst_pkg::SMST_RD_CTRL_W-1:0] read_delay_control_i,
  input  wire logic [DW-1:0]                    mem_dq_i,
  output logic                                  req_ready_o,
  output logic                                  done_o,
  output logic [DW-1:0]                         rdata_o,
  output logic                                  mem_cs_n_o,
  output logic                                  mem_oe_n_o,
  output logic                                  mem_we_n_o,
  output logic [DW/8-1:0]                       byte_lane_strobe_n_o,
  output logic [AW-1:0]                         mem_addr_o,
  output logic [DW-1:0]                         mem_dq_o,
  output logic                                  mem_dq_oe_o
);
  import smst_pkg::*;

  localparam int unsigned BL = DW / 8;
  localparam int unsigned CW = WAIT_W + 1;

  if (WAIT_W < 1 || WAIT_W > 8 || DW < 8 || (DW % 8) != 0 || AW < 1)
  begin : g_chk
    $error("smst_seq: unsupported AW, DW or WAIT_W");
  end

  typedef struct packed {
    smst_state_t      state;
    logic             is_wr;
    logic             cs;
    logic             oe;
    logic             we;
    logic [BL-1:0]    byte_lane_strobe;
    logic             dq_oe;
    logic             done;
    logic [AW-1:0]    addr;
    logic [DW-1:0]    wdata;
    logic [DW-1:0]    rdata;
    logic [BL-1:0]    be;
    logic [CW-1:0]    rd_wid;
    logic [CW-1:0]    we_len;
    logic [WAIT_W-1:0] raw_oen;
    logic [WAIT_W-1:0] raw_rd;
    logic [WAIT_W-1:0] raw_wen;
    logic [WAIT_W-1:0] raw_wr;
    logic             raw_dly;
  } smst_seq_t;

  smst_seq_t st_ff;
  smst_seq_t nxt_st;

  logic          cnt_zero;
  logic          cnt_load;
  logic [CW-1:0] cnt_val;

  // widened copies of the wait fields
  logic [CW-1:0] oen_x, rd_x, wen_x, wr_x;
  logic          dly_bit, rd_ge, wr_ge;
  logic [CW-1:0] oen_plus, rd_dly, rd_wid0, rd_wid, wen_e, we_len;

  assign oen_x   = {1'b0, output_enable_wait_i};
  assign rd_x    = {1'b0, read_wait_i};
  assign wen_x   = {1'b0, write_enable_wait_i};
  assign wr_x    = {1'b0, write_wait_i};
  assign dly_bit = read_delay_control_i[SMST_RD_DELAY_BIT];
  assign rd_ge   = (rd_x >= oen_x);
  assign wr_ge   = (wr_x >= wen_x);

  // read delay: extra cycle allowed but capped at read_wait
  assign oen_plus = oen_x + CW'(dly_bit);
  assign rd_dly   = !rd_ge ? '0 :
                    (oen_plus > rd_x) ? rd_x : oen_plus;
  assign rd_wid0  = rd_ge ? CW'(rd_x - oen_x + 1'b1)
                          : CW'(rd_x + 1'b1);
  // shorter strobe with the delay bit, never below one cycle
  assign rd_wid   = (dly_bit && rd_wid0 > CW'(1)) ?
                    CW'(rd_wid0 - 1'b1) : rd_wid0;
  // write_wait below write_enable_wait clamps the lead to write_wait
  assign wen_e    = wr_ge ? wen_x : wr_x;
  assign we_len   = CW'(wr_x - wen_e);

  // access sequencer
  always_comb begin
    nxt_st      = st_ff;
    nxt_st.done = SMST_DONE_RST;
    cnt_load    = 1'b0;
    cnt_val     = '0;
    unique case (st_ff.state)
      SMST_IDLE: begin
        if (req_i) begin
          nxt_st.is_wr   = req_we_i;
          nxt_st.addr    = req_addr_i;
          nxt_st.wdata   = req_wdata_i;
          nxt_st.be      = req_be_i;
          nxt_st.rd_wid  = rd_wid;
          nxt_st.we_len  = we_len;
          nxt_st.raw_oen = output_enable_wait_i;
          nxt_st.raw_rd  = read_wait_i;
          nxt_st.raw_wen = write_enable_wait_i;
          nxt_st.raw_wr  = write_wait_i;
          nxt_st.raw_dly = dly_bit;
          nxt_st.cs      = 1'b1;
          nxt_st.dq_oe   = req_we_i;       // data first
          cnt_load       = 1'b1;
          if (req_we_i) begin
            if (wen_e == '0) begin
              nxt_st.state = SMST_LEAD;
              nxt_st.byte_lane_strobe   = req_be_i;
            end else begin
              nxt_st.state = SMST_SETUP;
              cnt_val      = CW'(wen_e - 1'b1);
            end
          end else if (rd_dly == '0) begin
            nxt_st.state = SMST_STROBE;
            nxt_st.oe    = 1'b1;
            nxt_st.byte_lane_strobe   = req_be_i;
            cnt_val      = CW'(rd_wid - 1'b1);
          end else begin
            nxt_st.state = SMST_SETUP;
            cnt_val      = CW'(rd_dly - 1'b1);
          end
        end
      end
      SMST_SETUP: begin
        if (cnt_zero) begin
          cnt_load   = 1'b1;
          nxt_st.byte_lane_strobe = st_ff.be;
          if (st_ff.is_wr) begin
            nxt_st.state = SMST_LEAD;
          end else begin
            nxt_st.state = SMST_STROBE;
            nxt_st.oe    = 1'b1;
            cnt_val      = CW'(st_ff.rd_wid - 1'b1);
          end
        end
      end
      SMST_LEAD: begin
        // byte lanes lead write enable by one cycle
        nxt_st.state = SMST_STROBE;
        nxt_st.we    = 1'b1;
        cnt_load     = 1'b1;
        cnt_val      = st_ff.we_len;
      end
      SMST_STROBE: begin
        if (cnt_zero) begin
          cnt_load = 1'b1;
          if (st_ff.is_wr) begin
            nxt_st.state = SMST_TAIL;
            nxt_st.we    = 1'b0;
            cnt_val      = CW'(SMST_WE_TAIL_CYC - 1);
          end else begin
            nxt_st.rdata = mem_dq_i;
            nxt_st.state = SMST_RECOV;
            nxt_st.oe    = 1'b0;
            nxt_st.byte_lane_strobe   = '0;
            nxt_st.cs    = 1'b0;
            nxt_st.done  = 1'b1;
            cnt_val      = CW'(SMST_RECOV_CYC - 1);
          end
        end
      end
      SMST_TAIL: begin
        // address and data stay put while lanes are still low
        if (cnt_zero) begin
          nxt_st.state = SMST_RECOV;
          nxt_st.byte_lane_strobe   = '0;
          nxt_st.cs    = 1'b0;
          nxt_st.done  = 1'b1;
          cnt_load     = 1'b1;
          cnt_val      = CW'(SMST_RECOV_CYC - 1);
        end
      end
      SMST_RECOV: begin
        // data still driven in the cycle after chip select rises
        if (cnt_zero) begin
          nxt_st.state = SMST_IDLE;
          nxt_st.dq_oe = 1'b0;
        end
      end
    endcase
  end

  always_ff @(posedge sys_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      st_ff       <= '0;
      st_ff.state <= SMST_IDLE;
      st_ff.oe    <= SMST_STROBE_RST;
      st_ff.we    <= SMST_STROBE_RST;
    end else if (ce_i) begin
      st_ff <= nxt_st;
    end
  end

  smst_wait_cnt #(
    .CW (CW)
  ) u_cnt (
    .sys_clk_i  (sys_clk_i),
    .resetn_i   (resetn_i),
    .ce_i       (ce_i),
    .load_i     (cnt_load),
    .load_val_i (cnt_val),
    .zero_o     (cnt_zero)
  );

  // memory pins are active low; internal flags are active high
  assign req_ready_o          = (st_ff.state == SMST_IDLE);
  assign done_o               = st_ff.done;
  assign rdata_o              = st_ff.rdata;
  assign mem_cs_n_o           = ~st_ff.cs;
  assign mem_oe_n_o           = ~st_ff.oe;
  assign mem_we_n_o           = ~st_ff.we;
  assign byte_lane_strobe_n_o = ~st_ff.byte_lane_strobe;
  assign mem_addr_o           = st_ff.addr;
  assign mem_dq_o             = st_ff.wdata;
  assign mem_dq_oe_o          = st_ff.dq_oe;

  // helper ages: cycles since chip select and since strobe start
  logic [7:0] h_cs_age_ff, h_str_age_ff;
  logic       h_str_seen_ff;
  always_ff @(posedge sys_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      h_cs_age_ff   <= '0;
      h_str_age_ff  <= '0;
      h_str_seen_ff <= 1'b0;
    end else if (ce_i) begin
      h_cs_age_ff   <= (st_ff.cs && nxt_st.cs) ? 8'(h_cs_age_ff + 1'b1)
                                               : 8'h00;
      h_str_age_ff  <= (st_ff.oe || st_ff.we) ? 8'(h_str_age_ff + 1'b1)
                                              : 8'h00;
      h_str_seen_ff <= st_ff.cs && (h_str_seen_ff || st_ff.oe || st_ff.we);
    end
  end

  default clocking cb @(posedge sys_clk_i); endclocking
  default disable iff (!resetn_i || !ce_i);

  a_oe_start_cycle: assert property ($fell(mem_oe_n_o) |->
    h_cs_age_ff == ((st_ff.raw_rd < st_ff.raw_oen) ? 0 :
      ((st_ff.raw_oen + st_ff.raw_dly > st_ff.raw_rd) ? st_ff.raw_rd
        : st_ff.raw_oen + st_ff.raw_dly)))
    else $error("read strobe started at the wrong cycle");
  a_rd_no_delay: assert property ($fell(mem_cs_n_o) &&
    !st_ff.is_wr && st_ff.raw_rd < st_ff.raw_oen |->
    !mem_oe_n_o && byte_lane_strobe_n_o != '1)
    else $error("output enable lagged chip select");
  a_rd_delay_cap: assert property ($fell(mem_oe_n_o) |->
    h_cs_age_ff <= st_ff.raw_rd)
    else $error("read strobe delay beyond read wait");
  a_oe_width: assert property ($rose(mem_oe_n_o) |->
    $past(h_str_age_ff) + 1 == st_ff.rd_wid)
    else $error("output enable width wrong");
  // width from the raw wait fields, not from the latched result
  a_oe_width_raw: assert property ($rose(mem_oe_n_o) &&
    !st_ff.raw_dly && st_ff.raw_rd >= st_ff.raw_oen |->
    $past(h_str_age_ff) == st_ff.raw_rd - st_ff.raw_oen)
    else $error("output enable width differs from wait fields");
  a_oe_short_dly: assert property ($rose(mem_oe_n_o) &&
    st_ff.raw_dly && st_ff.raw_rd > st_ff.raw_oen |->
    $past(h_str_age_ff) == st_ff.raw_rd - st_ff.raw_oen - 1)
    else $error("delay bit did not shorten output enable");
  a_strobe_min: assert property ($rose(mem_cs_n_o) |->
    h_str_seen_ff)
    else $error("access ended with no strobe cycle");
  a_we_start: assert property ($fell(mem_we_n_o) |->
    h_cs_age_ff == ((st_ff.raw_wr >= st_ff.raw_wen) ? st_ff.raw_wen
      : st_ff.raw_wr) + 1 && $past(byte_lane_strobe_n_o) != '1)
    else $error("write enable not one cycle after byte lanes");
  a_we_width: assert property ($rose(mem_we_n_o) |->
    $past(h_str_age_ff) == st_ff.we_len)
    else $error("write enable width wrong");
  a_bls_tail: assert property ($rose(mem_we_n_o) &&
    st_ff.be != '0 |-> byte_lane_strobe_n_o != '1
    ##1 byte_lane_strobe_n_o == '1 && mem_cs_n_o)
    else $error("byte lanes did not outlast write enable by one");
  a_wdata_setup: assert property ($fell(mem_we_n_o) |->
    $past(mem_dq_oe_o) && $stable(mem_dq_o))
    else $error("write data not valid before write enable");
  a_wr_hold: assert property ($rose(mem_we_n_o) |->
    $stable(mem_addr_o) && $stable(mem_dq_o) && mem_dq_oe_o
    ##1 $stable(mem_addr_o) && $stable(mem_dq_o) && mem_dq_oe_o)
    else $error("address or data changed right after write enable");
  a_rd_capture: assert property ($rose(mem_oe_n_o) |->
    rdata_o == $past(mem_dq_i) && done_o && mem_cs_n_o)
    else $error("read data not taken in last strobe cycle");

  c_read_delayed: cover property ($fell(mem_oe_n_o) && h_cs_age_ff > 0);
  c_read_direct:  cover property ($fell(mem_oe_n_o) && h_cs_age_ff == 0);
  c_write_done:   cover property (done_o && st_ff.is_wr);
  c_back_to_back: cover property (done_o ##2 $fell(mem_cs_n_o));

endmodule : smst_seq

// >>> src/smst_pkg.sv
package smst_pkg;

  // sequencer phases of one static-memory access
  typedef enum logic [2:0] {
    SMST_IDLE,
    SMST_SETUP,
    SMST_LEAD,
    SMST_STROBE,
    SMST_TAIL,
    SMST_RECOV
  } smst_state_t;

  // bit of the read-delay control word that adds the extra read cycle
  localparam int unsigned SMST_RD_DELAY_BIT = 5;
  localparam int unsigned SMST_RD_CTRL_W    = 8;
  // byte-lane strobes outlast write enable by this many cycles
  localparam int unsigned SMST_WE_TAIL_CYC  = 1;
  // idle cycles after chip select rises, keeping the address stable
  localparam int unsigned SMST_RECOV_CYC    = 1;
  // values after reset
  localparam logic        SMST_STROBE_RST   = 1'b0;
  localparam logic        SMST_DONE_RST     = 1'b0;

endpackage : smst_pkg

// >>> src/smst_wait_cnt.sv
`timescale 1ns/1ps
// loadable down counter that times each phase of an access
module smst_wait_cnt #(
  parameter int unsigned CW = 5
) (
  input  wire logic          sys_clk_i,
  input  wire logic          resetn_i,
  input  wire logic          ce_i,
  input  wire logic          load_i,
  input  wire logic [CW-1:0] load_val_i,
  output logic               zero_o
);
  import smst_pkg::*;

  typedef struct packed {
    logic [CW-1:0] cnt;
  } smst_cnt_t;

  smst_cnt_t cnt_ff;
  smst_cnt_t nxt_cnt;

  if (CW < 1) begin : g_chk
    $error("smst_wait_cnt: CW must be at least 1");
  end

  // load wins over counting; holds at zero when idle
  always_comb begin
    nxt_cnt = cnt_ff;
    if (load_i) begin
      nxt_cnt.cnt = load_val_i;
    end else if (cnt_ff.cnt != '0) begin
      nxt_cnt.cnt = cnt_ff.cnt - 1'b1;
    end
  end

  always_ff @(posedge sys_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      cnt_ff <= '0;
    end else if (ce_i) begin
      cnt_ff <= nxt_cnt;
    end
  end

  assign zero_o = (cnt_ff.cnt == '0);

endmodule : smst_wait_cnt

// >>> tb/smst_sram_model.sv
`timescale 1ns/1ps
// behavioural async static ram seen at the clock edges
module smst_sram_model (
  input  wire logic        sys_clk_i,
  input  wire logic        cs_n_i,
  input  wire logic        oe_n_i,
  input  wire logic        we_n_i,
  input  wire logic [1:0]  bls_n_i,
  input  wire logic [23:0] addr_i,
  input  wire logic [15:0] dq_i,
  input  wire logic [1:0]  lat_i,
  output logic      [15:0] dq_o
);
  logic [15:0] mem [0:255];
  logic [15:0] last;
  logic [1:0]  run;
  logic        drv;
  // seeded contents, so a read needs no earlier write
  initial begin
    run = 2'h0;
    last = 16'h0000;
    for (int i = 0; i < 256; i++) begin
      mem[i] = {i[7:0], ~i[7:0]};
    end
  end
  // slow part: data only after lat_i output-enable cycles
  assign drv = !cs_n_i && !oe_n_i && run >= lat_i;
  // a released bus shows no stale copy of the last word
  assign dq_o = drv ? mem[addr_i[7:0]] : ~last;
  // per-lane write while selected with write enable low
  always @(posedge sys_clk_i) begin
    if (!cs_n_i && !oe_n_i) begin
      run <= (run == 2'h3) ? run : run + 2'h1;
    end else begin
      run <= 2'h0;
    end
    if (drv) last <= dq_o;
    if (!cs_n_i && !we_n_i && !bls_n_i[0]) mem[addr_i[7:0]][7:0] <= dq_i[7:0];
    if (!cs_n_i && !we_n_i && !bls_n_i[1]) mem[addr_i[7:0]][15:8] <= dq_i[15:8];
  end
endmodule : smst_sram_model

// >>> tb/testbench.sv
`timescale 1ns/1ps
module testbench;
  logic        sys_clk_i, resetn_i, ce_i, req_i, req_we_i;
  logic        req_ready_o, done_o, mem_cs_n_o, mem_oe_n_o;
  logic        mem_we_n_o, mem_dq_oe_o;
  logic [23:0] req_addr_i, mem_addr_o;
  logic [15:0] req_wdata_i, mem_dq_i, rdata_o, mem_dq_o;
  logic [1:0]  req_be_i, byte_lane_strobe_n_o, lat, bl_seen;
  logic [3:0]  oen, rdw, wenw, wrw;
  logic [7:0]  ctl;
  int          mismatches, n_checks, oe_first, oe_cnt, we_first;
  int          we_cnt, bl_first, bl_cnt, done_k;

  smst_seq #(.AW(24), .DW(16), .WAIT_W(4)) smst_seq_i (
    .sys_clk_i(sys_clk_i), .resetn_i(resetn_i), .ce_i(ce_i),
    .req_i(req_i), .req_we_i(req_we_i), .req_addr_i(req_addr_i),
    .req_wdata_i(req_wdata_i), .req_be_i(req_be_i),
    .output_enable_wait_i(oen), .read_wait_i(rdw),
    .write_enable_wait_i(wenw), .write_wait_i(wrw),
    .read_delay_control_i(ctl), .mem_dq_i(mem_dq_i),
    .req_ready_o(req_ready_o), .done_o(done_o), .rdata_o(rdata_o),
    .mem_cs_n_o(mem_cs_n_o), .mem_oe_n_o(mem_oe_n_o),
    .mem_we_n_o(mem_we_n_o), .byte_lane_strobe_n_o(byte_lane_strobe_n_o),
    .mem_addr_o(mem_addr_o), .mem_dq_o(mem_dq_o),
    .mem_dq_oe_o(mem_dq_oe_o));

  smst_sram_model smst_sram_model_i (
    .sys_clk_i(sys_clk_i), .cs_n_i(mem_cs_n_o), .oe_n_i(mem_oe_n_o),
    .we_n_i(mem_we_n_o), .bls_n_i(byte_lane_strobe_n_o),
    .addr_i(mem_addr_o), .dq_i(mem_dq_o), .lat_i(lat), .dq_o(mem_dq_i));

  // 25 MHz
  initial begin
    sys_clk_i = 1'b0;
    forever #20 sys_clk_i = ~sys_clk_i;
  end

  function automatic logic [15:0] pat(input logic [7:0] a);
    return {a, ~a};
  endfunction : pat

  task automatic chk(input string what, input logic [31:0] exp,
                     input logic [31:0] got);
    n_checks++;
    if (got !== exp) begin
      mismatches++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
    end
  endtask : chk

  task automatic print_verdict;
    $display("checks %0d mismatches %0d", n_checks, mismatches);
    if (mismatches == 0 && n_checks > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask : print_verdict

  // bounded wait for the idle state; a miss ends the run
  task automatic wait_ready;
    int k;
    for (k = 0; k < 50 && req_ready_o !== 1'b1; k++) @(negedge sys_clk_i);
    if (req_ready_o !== 1'b1) begin
      mismatches++;
      $display("CHECK FAILED ready expected 1 seen %b", req_ready_o);
      print_verdict();
    end
  endtask : wait_ready

  // one access; strobe starts and widths counted from the first cs cycle
  task automatic run(input logic we, input logic [23:0] a,
                     input logic [15:0] d, input logic [1:0] be,
                     input logic [3:0] oe_w, rd_w, we_w, wr_w,
                     input logic [7:0] c);
    int k;
    logic fin, pwe, pdo;
    logic [15:0] pdq;
    fin = 1'b0; pwe = 1'b1; pdo = 1'b0; pdq = '0;
    oe_cnt = 0; we_cnt = 0; bl_cnt = 0;
    wait_ready();
    req_i = 1'b1; req_we_i = we; req_addr_i = a; req_wdata_i = d;
    req_be_i = be; oen = oe_w; rdw = rd_w; wenw = we_w; wrw = wr_w;
    ctl = c;
    @(negedge sys_clk_i);
    req_i = 1'b0;
    for (k = 0; k < 64 && !fin; k++) begin
      if (mem_oe_n_o === 1'b0) begin
        if (oe_cnt == 0) oe_first = k;
        oe_cnt++;
      end
      if (mem_we_n_o === 1'b0) begin
        if (we_cnt == 0) we_first = k;
        we_cnt++;
      end
      if (byte_lane_strobe_n_o !== 2'b11) begin
        if (bl_cnt == 0) bl_first = k;
        bl_cnt++;
        bl_seen = byte_lane_strobe_n_o;
      end
      if (pwe === 1'b1 && mem_we_n_o === 1'b0) begin
        chk("data before we", d, pdq);
        chk("dq drive before we", 1, pdo);
      end
      if (pwe === 1'b0 && mem_we_n_o === 1'b1) begin
        chk("addr after we", a, mem_addr_o);
        chk("data after we", d, mem_dq_o);
        chk("dq drive after we", 1, mem_dq_oe_o);
      end
      pwe = mem_we_n_o; pdq = mem_dq_o; pdo = mem_dq_oe_o;
      if (done_o === 1'b1) begin
        fin = 1'b1;
        done_k = k;
      end else @(negedge sys_clk_i);
    end
    // a hung access ends the run at once
    if (!fin) begin
      mismatches++;
      $display("CHECK FAILED done expected 1 seen 0");
      print_verdict();
    end
  endtask : run

  task automatic t_read_basic;
    run(0, 24'h12, 0, 2'b11, 1, 2, 0, 0, 0);
    chk("oe start", 1, oe_first);
    chk("bls start", 1, bl_first);
    chk("oe width", 2, oe_cnt);
    chk("bls width", 2, bl_cnt);
    chk("read data", pat(8'h12), rdata_o);
    chk("done cycle", 3, done_k);
  endtask : t_read_basic

  task automatic t_read_short;
    run(0, 24'h21, 0, 2'b10, 3, 1, 0, 0, 0);
    chk("oe start", 0, oe_first);
    chk("bls start", 0, bl_first);
    chk("oe width", 2, oe_cnt);
    chk("bls lanes", 2'b01, bl_seen);
    chk("read data", pat(8'h21), rdata_o);
  endtask : t_read_short

  task automatic t_read_delay;
    run(0, 24'h55, 0, 2'b11, 1, 3, 0, 0, 8'h20);
    chk("oe start", 2, oe_first);
    chk("oe width", 2, oe_cnt);
    chk("read data", pat(8'h55), rdata_o);
    run(0, 24'h56, 0, 2'b11, 0, 0, 0, 0, 8'h20);
    chk("oe start cap", 0, oe_first);
    chk("oe width min", 1, oe_cnt);
    chk("read data", pat(8'h56), rdata_o);
  endtask : t_read_delay

  task automatic t_read_slow;
    lat = 2'h3;
    run(0, 24'h77, 0, 2'b11, 0, 3, 0, 0, 0);
    lat = 2'h0;
    chk("oe width", 4, oe_cnt);
    chk("read data", pat(8'h77), rdata_o);
  endtask : t_read_slow

  task automatic t_write_basic;
    run(1, 24'h34, 16'hbeef, 2'b01, 0, 0, 1, 2, 0);
    chk("we start", 2, we_first);
    chk("bls start", 1, bl_first);
    chk("we width", 2, we_cnt);
    chk("bls width", 4, bl_cnt);
    chk("done cycle", 5, done_k);
    run(0, 24'h34, 0, 2'b11, 0, 1, 0, 0, 0);
    chk("read back", 16'h34ef, rdata_o);
  endtask : t_write_basic

  task automatic t_write_min;
    run(1, 24'h40, 16'h1234, 2'b11, 0, 0, 0, 0, 0);
    chk("we start", 1, we_first);
    chk("we width", 1, we_cnt);
    chk("bls width", 3, bl_cnt);
    run(1, 24'h41, 16'h5678, 2'b11, 0, 0, 3, 1, 0);
    chk("we width min", 1, we_cnt >= 1);
    chk("bls width min", 1, bl_cnt >= 1);
  endtask : t_write_min

  // clock enable low in the first strobe cycle must freeze the whole access
  task automatic t_freeze;
    int k;
    wait_ready();
    req_i = 1'b1; req_we_i = 1'b0; req_addr_i = 24'h000066;
    req_be_i = 2'b11; oen = 4'h0; rdw = 4'h2; ctl = 8'h00;
    @(negedge sys_clk_i);
    req_i = 1'b0;
    ce_i = 1'b0;
    repeat (3) @(negedge sys_clk_i);
    chk("oe_n frozen", 0, mem_oe_n_o);
    chk("cs_n frozen", 0, mem_cs_n_o);
    ce_i = 1'b1;
    for (k = 0; k < 8 && done_o !== 1'b1; k++) @(negedge sys_clk_i);
    chk("cycles after freeze", 3, k);
    chk("read data", pat(8'h66), rdata_o);
    if (done_o !== 1'b1) print_verdict();
  endtask : t_freeze

  // stimulus changes on the falling edge only
  initial begin
    resetn_i = 1'b0; ce_i = 1'b1; req_i = 1'b0; req_we_i = 1'b0;
    req_addr_i = '0; req_wdata_i = '0; req_be_i = '0; lat = 2'h0;
    oen = '0; rdw = '0; wenw = '0; wrw = '0; ctl = '0;
    mismatches = 0; n_checks = 0;
    repeat (12) @(negedge sys_clk_i);
    chk("ready in reset", 1, req_ready_o);
    chk("cs_n in reset", 1, mem_cs_n_o);
    resetn_i = 1'b1;
    t_read_basic();
    t_read_short();
    t_read_delay();
    t_read_slow();
    t_write_basic();
    t_write_min();
    t_freeze();
    print_verdict();
  end
endmodule : testbench
